//--- verilog/orb_out_reg.sv
`timescale 1ns/1ps
`include "orb_params.svh"

module orb_out_reg
  import orb_pkg::*;
#(
  parameter bit RIGHT_EDGE = 1'h1,
  parameter int FIFO_DEPTH = `ORB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   CLK_IN,
  input  wire logic                   NRST_IN,
  // Configuration
  input  wire logic [1:0]             MODE_IN,
  input  wire logic                   LATCH_MODE_IN,
  // Core data stream
  input  wire logic                   CORE_VALID_IN,
  output logic                        CORE_READY_OUT,
  input  wire logic [`ORB_DATA_W-1:0] CORE_DATA_FIRST_IN,
  input  wire logic [`ORB_DATA_W-1:0] CORE_DATA_SECOND_IN,
  // Shifted write strobe from outside
  input  wire logic                   SHIFTED_WRITE_STROBE_CLOCK_IN,
  // Pin side and status
  output logic [`ORB_DATA_W-1:0]      PIN_DATA_OUT,
  output logic                        SYS_PHASE_OUT,
  output logic                        UNDERRUN_OUT
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (FIFO_DEPTH < 2 || `ORB_SCLK_HALF_CYC != 1)
      $error("orb_out_reg: unsupported FIFO depth or clock ratio");
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  orb_mode_e mode;
  wire       mode_known = (MODE_IN == ORB_SDR) || (MODE_IN == ORB_DDR_GEN) || (MODE_IN == ORB_DDR_MEM);

  // Memory mode only on right edge cells, else generic DDR
  assign mode = !mode_known                               ? ORB_SDR :
                (MODE_IN == ORB_DDR_MEM && !RIGHT_EDGE)    ? ORB_DDR_GEN :
                orb_mode_e'(MODE_IN);

  wire is_sdr   = (mode == ORB_SDR);
  wire is_latch = is_sdr && LATCH_MODE_IN;

  // ----------------------------------------------------------------
  // System clock phase divider
  // ----------------------------------------------------------------
  // One phase bit stands for the cell system clock level
  logic phase;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      phase <= `ORB_RST_PHASE;
    else
      phase <= ~phase;
  end

  wire rise_ev = !phase;                       // Edge that raises the system clock
  wire fall_ev = phase;                        // Edge that lowers it

  // ----------------------------------------------------------------
  // Strobe synchroniser
  // ----------------------------------------------------------------
  logic strobe_meta;
  logic strobe_sync;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      strobe_meta <= 1'h0;
      strobe_sync <= 1'h0;
    end else begin
      strobe_meta <= SHIFTED_WRITE_STROBE_CLOCK_IN;
      strobe_sync <= strobe_meta;
    end
  end

  // ----------------------------------------------------------------
  // Input FIFO
  // ----------------------------------------------------------------
  orb_pair_s in_pair;
  orb_pair_s head;
  logic      head_valid;
  logic      pop;

  // Second word is ignored in SDR
  assign in_pair.first  = CORE_DATA_FIRST_IN;
  assign in_pair.second = is_sdr ? `ORB_DATA_W'(0) : CORE_DATA_SECOND_IN;

  orb_fifo #(
    .WIDTH ($bits(orb_pair_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .nrst_in       (NRST_IN),
    .in_valid_in   (CORE_VALID_IN),
    .in_ready_out  (CORE_READY_OUT),
    .in_data_in    (in_pair),
    .out_valid_out (head_valid),
    .out_ready_in  (pop),
    .out_data_out  (head)
  );

  // Flop and DDR modes take a pair at the rise, latch mode at the close
  wire take_ev = is_latch ? fall_ev : rise_ev;
  assign pop   = take_ev && head_valid;

  // ----------------------------------------------------------------
  // SDR storage element
  // ----------------------------------------------------------------
  logic [`ORB_DATA_W-1:0] sdr_reg;

  // Flop loads on rise; latch follows head while clock is high
  wire sdr_load = is_latch ? (phase && head_valid) : (rise_ev && head_valid);

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      sdr_reg <= `ORB_RST_DATA;
    else if (is_sdr && sdr_load)
      sdr_reg <= head.first;
  end

  // ----------------------------------------------------------------
  // DDR stages
  // ----------------------------------------------------------------
  logic [`ORB_DATA_W-1:0] rise_stage_reg;
  logic [`ORB_DATA_W-1:0] second_hold;
  logic [`ORB_DATA_W-1:0] fall_stage_reg;

  wire ddr_capture = !is_sdr && rise_ev && head_valid;

  // Both words captured at the rise
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rise_stage_reg <= `ORB_RST_DATA;
      second_hold    <= `ORB_RST_DATA;
    end else if (ddr_capture) begin
      rise_stage_reg <= head.first;
      second_hold    <= head.second;
    end
  end

  // Second word moves to the fall stage at the next fall
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      fall_stage_reg <= `ORB_RST_DATA;
    else if (!is_sdr && fall_ev)
      fall_stage_reg <= second_hold;
  end

  // ----------------------------------------------------------------
  // Output multiplexer
  // ----------------------------------------------------------------
  // Select follows system clock, or the strobe in memory mode
  wire mux_sel = (mode == ORB_DDR_MEM) ? strobe_sync : phase;
  wire [`ORB_DATA_W-1:0] ddr_word = mux_sel ? rise_stage_reg : fall_stage_reg;
  wire [`ORB_DATA_W-1:0] next_pin = is_sdr ? sdr_reg : ddr_word;

  // Pin data and status from flops
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PIN_DATA_OUT <= `ORB_RST_DATA;
      UNDERRUN_OUT <= 1'h0;
    end else begin
      PIN_DATA_OUT <= next_pin;
      UNDERRUN_OUT <= take_ev && !head_valid;
    end
  end

  assign SYS_PHASE_OUT = phase;

endmodule

//--- verilog/orb_params.svh
`ifndef ORB_PARAMS_SVH
`define ORB_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define ORB_DATA_W      1
`define ORB_FIFO_DEPTH  16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Fast clock period, ns
`define ORB_CLK_PERIOD_NS  25
// Fast clock cycles in each half of the cell system clock
`define ORB_SCLK_HALF_CYC  1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ORB_RST_DATA   1'h0
`define ORB_RST_PHASE  1'h0

`endif

//--- verilog/orb_pkg.sv
`include "orb_params.svh"

package orb_pkg;

  // ----------------------------------------------------------------
  // Output modes, Gray coded along SDR -> generic DDR -> memory DDR
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ORB_SDR     = 2'h0,
    ORB_DDR_GEN = 2'h1,
    ORB_DDR_MEM = 2'h3
  } orb_mode_e;

  // One word pair from the core
  typedef struct packed {
    logic [`ORB_DATA_W-1:0] first;
    logic [`ORB_DATA_W-1:0] second;
  } orb_pair_s;

endpackage

//--- verilog/orb_fifo.sv
`timescale 1ns/1ps
`include "orb_params.svh"

module orb_fifo
  import orb_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = `ORB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("orb_fifo: DEPTH must be a power of two >= 2");
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire  do_write = in_valid_in && in_ready_out;
  wire  do_load  = (count != '0) && (!out_valid_out || out_ready_in);

  // Full when every memory word is taken
  assign in_ready_out = (count < (AW+1)'(DEPTH));

  // Memory write, no reset needed on the array
  always_ff @(posedge clk_in) begin
    if (do_write)
      mem[wr_ptr] <= in_data_in;
  end

  // Pointers and fill count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_write)
        wr_ptr <= wr_ptr + AW'(1);
      if (do_load)
        rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(do_write) - (AW+1)'(do_load);
    end
  end

  // Registered head word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'h0;
      out_data_out  <= '0;
    end else if (do_load) begin
      out_valid_out <= 1'h1;
      out_data_out  <= mem[rd_ptr];
    end else if (out_ready_in) begin
      out_valid_out <= 1'h0;
    end
  end

endmodule

//--- bench/orb_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core logic and strobe source
// ----------------------------------------
module orb_core_model
  import orb_pkg::*;
(
  // Clock and status from the block
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  input  wire logic       phase_in,
  // Strobe source: 0 low, 1 high, 2 shifted
  input  wire logic [1:0] strobe_sel_in,
  // Stream to the block
  output logic            valid_out,
  output orb_pair_s       pair_out,
  output logic            strobe_out
);
  orb_pair_s q[$];
  logic      rdy;
  int        n;

  initial begin
    valid_out  = 1'h0;
    pair_out   = '0;
  end

  // Quarter period late copy of the system clock
  always @(negedge clk_in) begin
    strobe_out <= strobe_sel_in[1] ? phase_in : strobe_sel_in[0];
  end

  // Pairs back to back, each held until taken
  task automatic send_all();
    while (q.size() > 0) begin
      #1;
      valid_out = 1'h1;
      pair_out  = q[0];
      n = 0;
      do begin
        @(negedge clk_in);
        rdy = ready_in;
        @(posedge clk_in);
        n++;
      end while (rdy !== 1'h1 && n < 64);
      // A pair never taken counts as a mismatch
      if (rdy !== 1'h1) begin
        testbench.err_total++;
        $display("wrong value core ready expected 1 seen %b", rdy);
      end
      void'(q.pop_front());
    end
    #1;
    valid_out = 1'h0;
    pair_out  = ~pair_out;
  endtask
endmodule

//--- bench/orb_out_reg_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Output stage port checks
// ----------------------------------------
module orb_out_reg_chk
  import orb_pkg::*;
#(
  parameter bit RIGHT_EDGE = 1'h1,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, configuration
  input wire logic       CLK_IN,
  input wire logic       NRST_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic       LATCH_MODE_IN,
  // Stream, strobe, pin
  input wire logic       CORE_VALID_IN,
  input wire logic       CORE_READY_OUT,
  input wire logic       SHIFTED_WRITE_STROBE_CLOCK_IN,
  input wire logic       PIN_DATA_OUT,
  input wire logic       SYS_PHASE_OUT,
  input wire logic       UNDERRUN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  // Mode decode
  wire sdr_w = MODE_IN == ORB_SDR;
  wire mem_w = RIGHT_EDGE && MODE_IN == ORB_DDR_MEM;

  reset_values_a: assert property (!$past(NRST_IN) |->
    !SYS_PHASE_OUT && !PIN_DATA_OUT && CORE_READY_OUT && !UNDERRUN_OUT) else $error("reset values");
  phase_toggle_a: assert property ($past(NRST_IN) |-> SYS_PHASE_OUT != $past(SYS_PHASE_OUT))
    else $error("phase stuck");
  underrun_pulse_a: assert property ($stable({MODE_IN, LATCH_MODE_IN}) [*3] ##0 UNDERRUN_OUT
    ##1 $stable({MODE_IN, LATCH_MODE_IN}) |-> !UNDERRUN_OUT) else $error("underrun too long");
  full_after_push_a: assert property ($fell(CORE_READY_OUT) |-> $past(CORE_VALID_IN))
    else $error("full without push");
  full_drains_a: assert property (!CORE_READY_OUT |-> ##[1:4] CORE_READY_OUT)
    else $error("no drain");
  underrun_not_full_a: assert property (UNDERRUN_OUT |-> $past(CORE_READY_OUT))
    else $error("underrun while full");
  sdr_hold_a: assert property ((sdr_w && $stable({MODE_IN, LATCH_MODE_IN})) [*4]
    ##0 $changed(PIN_DATA_OUT) |=> $stable(PIN_DATA_OUT)) else $error("sdr pin too fast");
  mem_hold_a: assert property ((mem_w && $stable({MODE_IN, SHIFTED_WRITE_STROBE_CLOCK_IN})) [*6]
    ##0 $changed(PIN_DATA_OUT) |=> $stable(PIN_DATA_OUT)) else $error("mem pin ignores strobe");

  // Main scenarios
  cover property (UNDERRUN_OUT);
  cover property (!CORE_READY_OUT);
  cover property (mem_w && $changed(PIN_DATA_OUT));
endmodule

bind orb_out_reg orb_out_reg_chk #(.RIGHT_EDGE(RIGHT_EDGE), .FIFO_DEPTH(FIFO_DEPTH)) u_orb_out_reg_chk (
  .CLK_IN, .NRST_IN, .MODE_IN, .LATCH_MODE_IN, .CORE_VALID_IN, .CORE_READY_OUT,
  .SHIFTED_WRITE_STROBE_CLOCK_IN, .PIN_DATA_OUT, .SYS_PHASE_OUT, .UNDERRUN_OUT);

//--- bench/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Output stage testbench
// ----------------------------------------
module testbench;
  import orb_pkg::*;
  logic       clk, nrst, latch, valid, strobe, ready, pin, phase, under;
  logic [1:0] mode, ssel;
  orb_pair_s  pair;
  int         err_total, tests_run, lim;
  logic       got[$], want[$];
  bit         full_seen, under_seen;

  // Block under test
  orb_out_reg u_orb_out_reg (
    .CLK_IN(clk), .NRST_IN(nrst), .MODE_IN(mode), .LATCH_MODE_IN(latch),
    .CORE_VALID_IN(valid), .CORE_READY_OUT(ready), .CORE_DATA_FIRST_IN(pair.first),
    .CORE_DATA_SECOND_IN(pair.second), .SHIFTED_WRITE_STROBE_CLOCK_IN(strobe),
    .PIN_DATA_OUT(pin), .SYS_PHASE_OUT(phase), .UNDERRUN_OUT(under));
  // Core side and strobe source
  orb_core_model u_orb_core_model (
    .clk_in(clk), .ready_in(ready), .phase_in(phase), .strobe_sel_in(ssel),
    .valid_out(valid), .pair_out(pair), .strobe_out(strobe));

  // One clock for the whole cell
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Pin trace and flags, sampled mid-cycle
  always @(negedge clk) begin
    got.push_back(pin);
    if (ready === 1'h0) full_seen = 1'b1;
    if (under === 1'h1) under_seen = 1'b1;
  end

  task automatic check(input string name, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Send n pairs; kind 0 firsts, 1 seconds, 2 both interleaved
  task automatic stream(input logic [1:0] m, input logic lt, input logic [1:0] ss, input int n, input int kind);
    logic f, s;
    int   k, i, j;
    bit   ok;
    @(posedge clk);
    #1;
    mode = m;
    latch = lt;
    ssel = ss;
    repeat (8) @(posedge clk);
    got.delete();
    want.delete();
    full_seen = 1'b0;
    for (k = 0; k < n; k++) begin
      f = k[0] ^ k[2];
      s = (kind == 0) ? ~f : k[1];
      u_orb_core_model.q.push_back('{f, s});
      want.push_back(kind == 1 ? s : f);
      want.push_back(kind == 0 ? f : s);
    end
    u_orb_core_model.send_all();
    under_seen = 1'b0;
    for (lim = 0; lim < 200 && !under_seen; lim++) @(posedge clk);
    if (!under_seen) begin
      err_total++;
      $display("wrong value drain expected 1 seen 0");
      results();
    end
    repeat (6) @(posedge clk);
    ok = 1'b0;
    for (i = 0; i + want.size() <= got.size(); i++) begin
      for (j = 0; j < want.size() && got[i+j] === want[j]; j++) ;
      if (j == want.size()) ok = 1'b1;
    end
    check("pin stream", 1'h1, ok);
  endtask

  // Flop element, back to back until refused
  task automatic sdr_flop();
    stream(ORB_SDR, 1'h0, 2'h2, 40, 0);
    check("ready low when full", 1'b1, full_seen);
  endtask
  // Latch element
  task automatic sdr_latch();
    stream(ORB_SDR, 1'h1, 2'h2, 20, 0);
  endtask
  // Generic double rate ignores a held strobe
  task automatic ddr_gen();
    stream(ORB_DDR_GEN, 1'h0, 2'h1, 24, 2);
  endtask
  // Memory double rate with running shifted strobe
  task automatic mem_run();
    stream(ORB_DDR_MEM, 1'h0, 2'h2, 24, 2);
  endtask
  // Strobe held high picks the rise stage
  task automatic mem_high();
    stream(ORB_DDR_MEM, 1'h0, 2'h1, 20, 0);
  endtask
  // Strobe held low picks the fall stage
  task automatic mem_low();
    stream(ORB_DDR_MEM, 1'h0, 2'h0, 20, 1);
  endtask
  // Spare mode code falls back to flop SDR
  task automatic mode_spare();
    stream(2'h2, 1'h0, 2'h2, 12, 0);
  endtask

  // Main sequence
  initial begin
    nrst = 1'h0;
    mode = ORB_SDR;
    latch = 1'h0;
    ssel = 2'h0;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'h1;
    sdr_flop();
    sdr_latch();
    ddr_gen();
    mem_run();
    mem_high();
    mem_low();
    mode_spare();
    results();
  end
endmodule
